// [rtl/sitc_pkg.sv]
package sitc_pkg;

  // ---------------------------------------------------------------------------
  // Register offsets (4-bit register index).
  // ---------------------------------------------------------------------------
  localparam logic [3:0] ADDR_SERIAL_BYTE_BUFFER = 4'h0_00c;
  localparam logic [3:0] ADDR_INT_FLAGS_MASK     = 4'h0_00d;
  localparam logic [3:0] ADDR_TIMER_A_CONTROL    = 4'h0_00e;
  localparam logic [3:0] ADDR_TIMER_B_CONTROL    = 4'h0_00f;

  // ---------------------------------------------------------------------------
  // Interrupt flag positions.
  // ---------------------------------------------------------------------------
  localparam int INT_TIMER_A  = 0;
  localparam int INT_TIMER_B  = 1;
  localparam int INT_ALARM    = 2;
  localparam int INT_SERIAL   = 3;
  localparam int INT_FLAG     = 4;
  localparam int INT_SUMMARY  = 7;
  localparam int MASK_SET_CLR = 7;
  localparam int INT_SOURCES  = 5;

  // ---------------------------------------------------------------------------
  // Timer control field positions.
  // ---------------------------------------------------------------------------
  localparam int CTL_START     = 0;
  localparam int CTL_PORT_ON   = 1;
  localparam int CTL_TOGGLE    = 2;
  localparam int CTL_ONE_SHOT  = 3;
  localparam int CTL_LOAD      = 4;
  localparam int CTL_SRC_LO    = 5;
  localparam int CTL_SHIFT_OUT = 6;
  localparam int CTL_TOP       = 7;

  // Stored control bits; bit 4 is a strobe and reads zero.
  localparam logic [7:0] CTL_STORED_MASK = 8'h0_0ef;
  localparam logic [7:0] CTL_RESET       = 8'h0_000;
  localparam logic [7:0] BYTE_RESET      = 8'h0_000;

  // Timer B count source encodings.
  localparam logic [1:0] SRC_BUS      = 2'h0_0;
  localparam logic [1:0] SRC_PIN      = 2'h0_1;
  localparam logic [1:0] SRC_TA       = 2'h0_2;
  localparam logic [1:0] SRC_TA_GATED = 2'h0_3;

  localparam logic [3:0] BITS_PER_BYTE = 4'h0_008;

  typedef enum logic [1:0] {SITC_IDLE, SITC_SHIFT} sitc_tx_state_t;

endpackage

// [rtl/sitc_sync.sv]
`timescale 1ns/1ns
module sitc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] stage1;

  // Resets to the pulled-up idle level, so no false edge follows reset.
  always_ff @(posedge clk) begin
    if (rst) begin
      stage1 <= '1;
      q      <= '1;
    end else begin
      stage1 <= d;
      q      <= stage1;
    end
  end

endmodule // sitc_sync

// [rtl/sitc_top.sv]
// Notes on behaviour
// (RULE1) Input mode samples data on clock rise.
// (RULE2) Eight input clocks load buffer, raise flag.
// (RULE3) Output shifts per two timer A underflows.
// (RULE4) Buffer write starts output if continuous.
// (RULE5) Output bits change on falling clock.
// (RULE6) Eighth bit flags; pending byte continues seamlessly.
// (RULE7) Idle output: clock high, data holds.
// (RULE8) Bytes move most significant bit first.
// (RULE9) Five flags: A, B, alarm, serial, flag.
// (RULE10) Events set flags regardless of mask.
// (RULE11) Enabled flag sets summary, asserts request low.
// (RULE12) Reading flags clears all, releases request.
// (RULE13) Mask write bit 7 sets or clears.
// (RULE14) Bit 0 runs timer; one-shot clears it.
// (RULE15) Bit 1 routes timer to port line.
// (RULE16) Bit 2 toggle/pulse; bit 3 one-shot.
// (RULE17) Bit 4 force load strobe, reads zero.
// (RULE18) Count source select bits per timer.
// (RULE19) Timer A bit 6 selects shift direction.
// (RULE20) Timer A bit 7 selects line frequency.
// (RULE21) Timer B bit 7 routes clock writes.
// (RULE22) Unused bits ignore writes, read zero.
// (RULE23) Pulse one cycle; toggle high on start.
// (RULE24) Port output forces line direction out.
// (RULE25) Received byte holds until next completes.
`timescale 1ns/1ns
module sitc_top (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       serial_data_pin_in,
  output logic            serial_data_pin_out,
  output logic            serial_data_pin_oe,
  input  wire logic       count_clock_pin_in,
  output logic            count_clock_pin_out,
  output logic            count_clock_pin_oe,
  input  wire logic       first_timer_underflow_event,
  input  wire logic       second_timer_underflow_event,
  input  wire logic       alarm_match_event,
  input  wire logic       external_flag_event,
  output logic            irq_n,
  output logic            first_timer_run,
  output logic            second_timer_run,
  output logic            first_timer_force_load,
  output logic            second_timer_force_load,
  output logic            first_timer_tick,
  output logic            second_timer_tick,
  output logic            port_b_line_six,
  output logic            port_b_line_seven,
  output logic            port_b_line_six_oe,
  output logic            port_b_line_seven_oe,
  output logic            line_frequency_select,
  output logic            time_of_day_alarm_select
);

  // ---------------------------------------------------------------------------
  // Registers and pin synchronisation
  // ---------------------------------------------------------------------------
  logic [7:0] timer_a_control;
  logic [7:0] timer_b_control;
  logic [7:0] serial_byte_buffer;
  logic [4:0] int_flags;
  logic [4:0] int_mask;
  logic       int_summary;
  logic [7:0] shifter;
  logic [3:0] bit_count;
  logic       byte_pending;
  logic       half_phase;
  logic       cnt_prev;
  logic       cnt_s;
  logic       sp_s;
  logic       ta_uf;
  logic       tb_uf;
  logic       serial_done;
  logic       tog_a;
  logic       tog_b;
  sitc_pkg::sitc_tx_state_t tx_state;

  sitc_sync #(.W(2)) u_sync (
    .clk (clk),
    .rst (rst),
    .d   ({count_clock_pin_in, serial_data_pin_in}),
    .q   ({cnt_s, sp_s})
  );

  // Event inputs come from timer logic on this clock and need no synchroniser.
  assign ta_uf = first_timer_underflow_event;
  assign tb_uf = second_timer_underflow_event;

  logic wr_a;
  logic wr_b;
  logic wr_buf;
  logic wr_mask;
  logic rd_flags;
  logic cnt_rise;
  logic out_mode;
  assign wr_a     = wr && addr == sitc_pkg::ADDR_TIMER_A_CONTROL;
  assign wr_b     = wr && addr == sitc_pkg::ADDR_TIMER_B_CONTROL;
  assign wr_buf   = wr && addr == sitc_pkg::ADDR_SERIAL_BYTE_BUFFER;
  assign wr_mask  = wr && addr == sitc_pkg::ADDR_INT_FLAGS_MASK;
  assign rd_flags = rd && addr == sitc_pkg::ADDR_INT_FLAGS_MASK;
  assign cnt_rise = cnt_s && !cnt_prev;
  assign out_mode = timer_a_control[sitc_pkg::CTL_SHIFT_OUT];

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_prev <= 1'b1;
    end else begin
      cnt_prev <= cnt_s;
    end
  end

  // ---------------------------------------------------------------------------
  // Timer control registers
  // ---------------------------------------------------------------------------
  // Writes store only implemented bits; the load bit is a strobe. [RULE17] [RULE22]
  always_ff @(posedge clk) begin
    if (rst) begin
      timer_a_control <= sitc_pkg::CTL_RESET;
    end else if (wr_a) begin
      timer_a_control <= wdata & sitc_pkg::CTL_STORED_MASK; // [RULE19] [RULE20]
    end else if (ta_uf && timer_a_control[sitc_pkg::CTL_ONE_SHOT]) begin
      timer_a_control[sitc_pkg::CTL_START] <= 1'b0; // [RULE14]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      timer_b_control <= sitc_pkg::CTL_RESET;
    end else if (wr_b) begin
      timer_b_control <= wdata & sitc_pkg::CTL_STORED_MASK; // [RULE21]
    end else if (tb_uf && timer_b_control[sitc_pkg::CTL_ONE_SHOT]) begin
      timer_b_control[sitc_pkg::CTL_START] <= 1'b0; // [RULE14]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      first_timer_run         <= 1'b0;
      second_timer_run        <= 1'b0;
      first_timer_force_load  <= 1'b0;
      second_timer_force_load <= 1'b0;
      line_frequency_select   <= 1'b0;
      time_of_day_alarm_select <= 1'b0;
    end else begin
      first_timer_run  <= timer_a_control[sitc_pkg::CTL_START] &&
                          !(ta_uf && timer_a_control[sitc_pkg::CTL_ONE_SHOT]);
      second_timer_run <= timer_b_control[sitc_pkg::CTL_START] &&
                          !(tb_uf && timer_b_control[sitc_pkg::CTL_ONE_SHOT]);
      first_timer_force_load  <= wr_a && wdata[sitc_pkg::CTL_LOAD]; // [RULE17]
      second_timer_force_load <= wr_b && wdata[sitc_pkg::CTL_LOAD]; // [RULE17]
      line_frequency_select    <= timer_a_control[sitc_pkg::CTL_TOP]; // [RULE20]
      time_of_day_alarm_select <= timer_b_control[sitc_pkg::CTL_TOP]; // [RULE21]
    end
  end

  // ---------------------------------------------------------------------------
  // Count source ticks
  // ---------------------------------------------------------------------------
  // A tick tells the external counter when to decrement. [RULE18]
  always_ff @(posedge clk) begin
    if (rst) begin
      first_timer_tick  <= 1'b0;
      second_timer_tick <= 1'b0;
    end else begin
      first_timer_tick <= timer_a_control[sitc_pkg::CTL_SRC_LO] ? cnt_rise : 1'b1;
      case (timer_b_control[6:5])
        sitc_pkg::SRC_BUS:      second_timer_tick <= 1'b1;
        sitc_pkg::SRC_PIN:      second_timer_tick <= cnt_rise;
        sitc_pkg::SRC_TA:       second_timer_tick <= ta_uf;
        sitc_pkg::SRC_TA_GATED: second_timer_tick <= ta_uf && cnt_s;
        default:                second_timer_tick <= 1'b0;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Port B timer outputs
  // ---------------------------------------------------------------------------
  // Toggle state rises on each start so the first edge is predictable. [RULE23]
  always_ff @(posedge clk) begin
    if (rst) begin
      tog_a <= 1'b0;
      tog_b <= 1'b0;
    end else begin
      if (wr_a && wdata[sitc_pkg::CTL_START] && !timer_a_control[sitc_pkg::CTL_START]) begin
        tog_a <= 1'b1;
      end else if (ta_uf) begin
        tog_a <= !tog_a;
      end
      if (wr_b && wdata[sitc_pkg::CTL_START] && !timer_b_control[sitc_pkg::CTL_START]) begin
        tog_b <= 1'b1;
      end else if (tb_uf) begin
        tog_b <= !tog_b;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      port_b_line_six      <= 1'b0;
      port_b_line_seven    <= 1'b0;
      port_b_line_six_oe   <= 1'b0;
      port_b_line_seven_oe <= 1'b0;
    end else begin
      // Toggle or one-cycle pulse per underflow. [RULE15] [RULE16] [RULE23]
      port_b_line_six   <= timer_a_control[sitc_pkg::CTL_TOGGLE] ? tog_a : ta_uf;
      port_b_line_seven <= timer_b_control[sitc_pkg::CTL_TOGGLE] ? tog_b : tb_uf;
      port_b_line_six_oe   <= timer_a_control[sitc_pkg::CTL_PORT_ON]; // [RULE24]
      port_b_line_seven_oe <= timer_b_control[sitc_pkg::CTL_PORT_ON]; // [RULE24]
    end
  end

  // ---------------------------------------------------------------------------
  // Serial shifter
  // ---------------------------------------------------------------------------
  // Output mode only leaves idle while timer A runs continuously. [RULE4]
  logic ta_continuous;
  assign ta_continuous = timer_a_control[sitc_pkg::CTL_START] &&
                         !timer_a_control[sitc_pkg::CTL_ONE_SHOT];

  always_ff @(posedge clk) begin
    if (rst) begin
      tx_state            <= sitc_pkg::SITC_IDLE;
      shifter             <= sitc_pkg::BYTE_RESET;
      bit_count           <= 4'h0_000;
      byte_pending        <= 1'b0;
      half_phase          <= 1'b0;
      serial_byte_buffer  <= sitc_pkg::BYTE_RESET;
      serial_done         <= 1'b0;
      count_clock_pin_out <= 1'b1;
      serial_data_pin_out <= 1'b1;
    end else begin
      serial_done <= 1'b0;
      if (wr_buf) begin
        serial_byte_buffer <= wdata;
        byte_pending       <= out_mode;
      end
      if (!out_mode) begin
        tx_state            <= sitc_pkg::SITC_IDLE;
        count_clock_pin_out <= 1'b1;
        half_phase          <= 1'b0;
        if (cnt_rise) begin
          shifter <= {shifter[6:0], sp_s}; // [RULE1] [RULE8]
          if (bit_count == sitc_pkg::BITS_PER_BYTE - 4'h0_001) begin
            bit_count          <= 4'h0_000;
            serial_byte_buffer <= {shifter[6:0], sp_s}; // [RULE2] [RULE25]
            serial_done        <= 1'b1; // [RULE2]
          end else begin
            bit_count <= bit_count + 4'h0_001;
          end
        end
      end else begin
        case (tx_state)
          sitc_pkg::SITC_IDLE: begin
            count_clock_pin_out <= 1'b1; // [RULE7]
            half_phase          <= 1'b0;
            bit_count           <= 4'h0_000;
            if ((byte_pending || wr_buf) && ta_continuous && !wr_buf) begin
              shifter      <= serial_byte_buffer;
              byte_pending <= 1'b0;
              tx_state     <= sitc_pkg::SITC_SHIFT; // [RULE4]
            end
          end
          sitc_pkg::SITC_SHIFT: begin
            if (ta_uf) begin
              // Two underflows make one bit period. [RULE3]
              half_phase <= !half_phase;
              if (!half_phase) begin
                count_clock_pin_out <= 1'b0;
                serial_data_pin_out <= shifter[7]; // [RULE5] [RULE8]
                shifter             <= {shifter[6:0], 1'b0};
              end else begin
                count_clock_pin_out <= 1'b1;
                if (bit_count == sitc_pkg::BITS_PER_BYTE - 4'h0_001) begin
                  bit_count   <= 4'h0_000;
                  serial_done <= 1'b1; // [RULE6]
                  if (byte_pending && !wr_buf) begin
                    shifter      <= serial_byte_buffer; // [RULE6]
                    byte_pending <= 1'b0;
                  end else begin
                    tx_state <= sitc_pkg::SITC_IDLE; // [RULE7]
                  end
                end else begin
                  bit_count <= bit_count + 4'h0_001;
                end
              end
            end
          end
          default: tx_state <= sitc_pkg::SITC_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      serial_data_pin_oe <= 1'b0;
      count_clock_pin_oe <= 1'b0;
    end else begin
      serial_data_pin_oe <= out_mode; // [RULE19]
      count_clock_pin_oe <= out_mode; // [RULE3]
    end
  end

  // ---------------------------------------------------------------------------
  // Interrupt flags and mask
  // ---------------------------------------------------------------------------
  logic [4:0] events;
  assign events = {external_flag_event, serial_done, alarm_match_event, tb_uf, ta_uf}; // [RULE9]

  // A new event in the read cycle survives the read-to-clear.
  always_ff @(posedge clk) begin
    if (rst) begin
      int_flags   <= 5'h0_00;
      int_summary <= 1'b0;
    end else begin
      int_flags   <= (rd_flags ? 5'h0_00 : int_flags) | events; // [RULE10] [RULE12]
      int_summary <= (rd_flags ? 1'b0 : int_summary) |
                     (|(((rd_flags ? 5'h0_00 : int_flags) | events) & int_mask)); // [RULE11]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      int_mask <= 5'h0_00;
    end else if (wr_mask) begin
      if (wdata[sitc_pkg::MASK_SET_CLR]) begin
        int_mask <= int_mask | wdata[4:0]; // [RULE13]
      end else begin
        int_mask <= int_mask & ~wdata[4:0]; // [RULE13]
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_n <= 1'b1;
    end else begin
      irq_n <= !(int_summary && !rd_flags); // [RULE11] [RULE12]
    end
  end

  // ---------------------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 8'h0_000;
    end else if (rd) begin
      case (addr)
        sitc_pkg::ADDR_SERIAL_BYTE_BUFFER: rdata <= serial_byte_buffer;
        sitc_pkg::ADDR_INT_FLAGS_MASK:     rdata <= {int_summary, 2'b00, int_flags}; // [RULE22]
        sitc_pkg::ADDR_TIMER_A_CONTROL:    rdata <= timer_a_control;
        sitc_pkg::ADDR_TIMER_B_CONTROL:    rdata <= timer_b_control;
        default:                           rdata <= 8'h0_000;
      endcase
    end else begin
      rdata <= 8'h0_000;
    end
  end

endmodule // sitc_top

// [verification/sitc_top_sva.sv]
`timescale 1ns/1ns
// ---------------------------------------------------------------------------
// Port checker for the serial, interrupt and timer control block.
// ---------------------------------------------------------------------------
module sitc_chk (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       serial_data_pin_out,
  input wire logic       count_clock_pin_out,
  input wire logic       count_clock_pin_oe,
  input wire logic       first_timer_underflow_event,
  input wire logic       second_timer_underflow_event,
  input wire logic       alarm_match_event,
  input wire logic       external_flag_event,
  input wire logic       irq_n,
  input wire logic       first_timer_run,
  input wire logic       second_timer_run,
  input wire logic       first_timer_force_load,
  input wire logic       port_b_line_six,
  input wire logic       port_b_line_six_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [7:0] ctl_a;
  logic       any_ev;
  // The shadow misses the one-shot clear of the start bit, so only mode bits are used.
  always_ff @(posedge clk) begin
    if (rst) begin
      ctl_a <= 8'h00;
    end else if (wr && addr == sitc_pkg::ADDR_TIMER_A_CONTROL) begin
      ctl_a <= wdata;
    end
  end
  assign any_ev = first_timer_underflow_event | second_timer_underflow_event
                | alarm_match_event | external_flag_event;
  sequence s_flag_read;
    rd && addr == sitc_pkg::ADDR_INT_FLAGS_MASK;
  endsequence
  sequence s_load_a;
    wr && addr == sitc_pkg::ADDR_TIMER_A_CONTROL && wdata[4];
  endsequence
  AST_FLAG_READ_RELEASE: assert property (s_flag_read ##0 (!any_ev && !$past(any_ev)) |=> irq_n)
    else $error("request still low after flag read");
  AST_FLAG_READ_ZERO_BITS: assert property (s_flag_read |=> rdata[6:5] == 2'b00)
    else $error("unused flag bits read nonzero");
  AST_FORCE_LOAD_CAUSE: assert property (s_load_a |=> first_timer_force_load)
    else $error("force load pulse missing");
  AST_FORCE_LOAD_ONLY: assert property (first_timer_force_load
      |-> $past(wr && addr == sitc_pkg::ADDR_TIMER_A_CONTROL && wdata[4]))
    else $error("force load pulse without a load write");
  AST_ONE_SHOT_STOP: assert property (first_timer_underflow_event && ctl_a[3] && !wr
      |=> !first_timer_run)
    else $error("one-shot underflow left the timer running");
  AST_RUN_B: assert property (wr && addr == sitc_pkg::ADDR_TIMER_B_CONTROL
      && !second_timer_underflow_event ##1 !second_timer_underflow_event
      |=> second_timer_run == $past(wdata[0], 2))
    else $error("second timer run level differs from start bit");
  AST_PORT_DIR: assert property (port_b_line_six_oe == $past(ctl_a[1]))
    else $error("port line direction differs from port-on bit");
  AST_PULSE_START: assert property (first_timer_underflow_event && first_timer_run
      && !ctl_a[2] && !wr |=> port_b_line_six)
    else $error("no port pulse after underflow");
  AST_PULSE_END: assert property (port_b_line_six && !ctl_a[2] && !$past(ctl_a[2])
      |-> $past(first_timer_underflow_event))
    else $error("port pulse longer than one cycle");
  AST_DATA_ON_FALL: assert property (count_clock_pin_oe && $past(count_clock_pin_oe)
      && $changed(serial_data_pin_out) |-> $fell(count_clock_pin_out))
    else $error("serial data changed away from a falling shift clock");
  AST_SHIFT_DIR: assert property ($rose(ctl_a[6]) |-> ##[0:2] count_clock_pin_oe)
    else $error("shift clock not driven in output mode");
endmodule // sitc_chk
bind sitc_top sitc_chk i_chk (
  .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .serial_data_pin_out(serial_data_pin_out), .count_clock_pin_out(count_clock_pin_out),
  .count_clock_pin_oe(count_clock_pin_oe), .irq_n(irq_n),
  .first_timer_underflow_event(first_timer_underflow_event),
  .second_timer_underflow_event(second_timer_underflow_event),
  .alarm_match_event(alarm_match_event), .external_flag_event(external_flag_event),
  .first_timer_run(first_timer_run), .second_timer_run(second_timer_run),
  .first_timer_force_load(first_timer_force_load), .port_b_line_six(port_b_line_six),
  .port_b_line_six_oe(port_b_line_six_oe)
);

// [verification/sitc_peer.sv]
`timescale 1ns/1ns
// ---------------------------------------------------------------------------
// Peer shift device on the open-drain link; a driver of 1 releases the line.
// ---------------------------------------------------------------------------
module sitc_peer #(
  parameter int HALF = 160
) (
  input  wire logic  data_line,
  input  wire logic  clock_line,
  output logic       data_drv,
  output logic       clock_drv,
  output logic [7:0] rx_byte,
  output logic       rx_stb
);
  logic [7:0] shreg;
  logic       driving;
  int         nbits;
  initial begin
    data_drv = 1'b1;
    clock_drv = 1'b1;
    rx_byte = 8'h00;
    rx_stb = 1'b0;
    driving = 1'b0;
    nbits = 0;
  end
  // The clock stands high between frames; data is held past each rising edge.
  task automatic send_bits(input logic [7:0] b, input int n);
    driving = 1'b1;
    #13;
    for (int i = 7; i > 7 - n; i--) begin
      clock_drv = 1'b0;
      data_drv = b[i];
      #(HALF);
      clock_drv = 1'b1;
      #(HALF);
    end
    data_drv = 1'b1;
    driving = 1'b0;
  endtask
  always @(posedge clock_line) begin
    // The power-up rise of the released line is not a shift clock.
    if (!driving && $time > 0) begin
      shreg = {shreg[6:0], data_line};
      nbits = nbits + 1;
      if (nbits == 8) begin
        nbits = 0;
        rx_byte = shreg;
        rx_stb = 1'b1;
        #1 rx_stb = 1'b0;
      end
    end
  end
endmodule // sitc_peer

// [verification/test_serial_shift_irq_timer_ctrl.sv]
`timescale 1ns/1ns
module test_serial_shift_irq_timer_ctrl;
  logic       clk, rst, wr, rd, rd_seen, rx_stb;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, rx_byte, b1, b2, b3, r, rd_q[$], rx_q[$];
  logic [4:0] ev;
  logic       sd_out, sd_oe, cc_out, cc_oe, sd_line, cc_line, peer_sd, peer_cc;
  logic       irq_n, run_a, run_b, pb6, pb6_oe, lfs, tas;
  int         mismatches, n_checks, cycles, seed;
  // Wired-AND with a pull-up; an unknown enable counts as released.
  assign sd_line = ((sd_oe === 1'b1) ? sd_out : 1'b1) & peer_sd;
  assign cc_line = ((cc_oe === 1'b1) ? cc_out : 1'b1) & peer_cc;
  sitc_top i_dut (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .serial_data_pin_in(sd_line), .serial_data_pin_out(sd_out), .serial_data_pin_oe(sd_oe),
    .count_clock_pin_in(cc_line), .count_clock_pin_out(cc_out), .count_clock_pin_oe(cc_oe),
    .first_timer_underflow_event(ev[0]), .second_timer_underflow_event(ev[1]),
    .alarm_match_event(ev[2]), .external_flag_event(ev[4]), .irq_n(irq_n),
    .first_timer_run(run_a), .second_timer_run(run_b), .first_timer_force_load(),
    .second_timer_force_load(), .first_timer_tick(), .second_timer_tick(),
    .port_b_line_six(pb6), .port_b_line_seven(), .port_b_line_six_oe(pb6_oe),
    .port_b_line_seven_oe(), .line_frequency_select(lfs), .time_of_day_alarm_select(tas)
  );
  sitc_peer i_peer (
    .data_line(sd_line), .clock_line(cc_line), .data_drv(peer_sd), .clock_drv(peer_cc),
    .rx_byte(rx_byte), .rx_stb(rx_stb)
  );
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
    rd_q.push_back(exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic pulse(input int i, input int gap);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev[i] <= 1'b0;
    repeat (gap) @(posedge clk);
  endtask
  // Reads are compared in the one cycle where the answer stands.
  always @(posedge clk) begin
    if (rd_seen) check(rdata, rd_q.pop_front());
    rd_seen <= rd;
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      final_report();
    end
  end
  always @(posedge rx_stb) check(rx_byte, rx_q.size() ? rx_q.pop_front() : ~rx_byte);
  initial begin
    seed = 98;
    rst = 1'b1;
    {addr, wdata, wr, rd, rd_seen, ev} = '0;
    {mismatches, n_checks, cycles} = '0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 5; i++) begin
      if (i == 3) continue;
      pulse(i, 1);
      rd_reg(sitc_pkg::ADDR_INT_FLAGS_MASK, 8'h01 << i);
    end
    wr_reg(sitc_pkg::ADDR_INT_FLAGS_MASK, 8'h85);
    pulse(1, 2);
    check(irq_n, 8'h01);
    rd_reg(sitc_pkg::ADDR_INT_FLAGS_MASK, 8'h02);
    pulse(2, 2);
    check(irq_n, 8'h00);
    rd_reg(sitc_pkg::ADDR_INT_FLAGS_MASK, 8'h84);
    check(irq_n, 8'h01);
    wr_reg(sitc_pkg::ADDR_INT_FLAGS_MASK, 8'h04);
    pulse(2, 2);
    check(irq_n, 8'h01);
    pulse(0, 2);
    check(irq_n, 8'h00);
    rd_reg(sitc_pkg::ADDR_INT_FLAGS_MASK, 8'h85);
    wr_reg(sitc_pkg::ADDR_INT_FLAGS_MASK, 8'h1f);
    for (int i = 0; i < 6; i++) begin
      r = $random(seed);
      wr_reg(i[0] ? sitc_pkg::ADDR_TIMER_B_CONTROL : sitc_pkg::ADDR_TIMER_A_CONTROL, r);
      @(posedge clk);
      check(i[0] ? run_b : run_a, r[0]);
      check(i[0] ? tas : lfs, r[7]);
      if (!i[0]) check(pb6_oe, r[1]);
      rd_reg(addr, r & sitc_pkg::CTL_STORED_MASK);
    end
    wr_reg(4'h3, 8'hff);
    rd_reg(4'h3, 8'h00);
    wr_reg(sitc_pkg::ADDR_TIMER_A_CONTROL, 8'h1b);
    pulse(0, 1);
    check(run_a, 8'h00);
    rd_reg(sitc_pkg::ADDR_TIMER_A_CONTROL, 8'h0a);
    wr_reg(sitc_pkg::ADDR_TIMER_A_CONTROL, 8'h07);
    @(posedge clk);
    check(pb6, 8'h01);
    pulse(0, 2);
    check(pb6, 8'h00);
    rd_reg(sitc_pkg::ADDR_INT_FLAGS_MASK, 8'h01);
    wr_reg(sitc_pkg::ADDR_TIMER_A_CONTROL, 8'h41);
    b1 = $random(seed);
    b2 = $random(seed);
    rx_q.push_back(b1);
    rx_q.push_back(b2);
    wr_reg(sitc_pkg::ADDR_SERIAL_BYTE_BUFFER, b1);
    repeat (6) pulse(0, 3);
    wr_reg(sitc_pkg::ADDR_SERIAL_BYTE_BUFFER, b2);
    repeat (30) pulse(0, 3);
    check(cc_out, 8'h01);
    check(sd_out, b2[0]);
    rd_reg(sitc_pkg::ADDR_INT_FLAGS_MASK, 8'h09);
    wr_reg(sitc_pkg::ADDR_TIMER_A_CONTROL, 8'h00);
    repeat (4) @(posedge clk);
    b3 = $random(seed);
    i_peer.send_bits(b3, 8);
    repeat (6) @(posedge clk);
    rd_reg(sitc_pkg::ADDR_SERIAL_BYTE_BUFFER, b3);
    rd_reg(sitc_pkg::ADDR_INT_FLAGS_MASK, 8'h08);
    i_peer.send_bits(8'ha5, 4);
    repeat (6) @(posedge clk);
    rd_reg(sitc_pkg::ADDR_SERIAL_BYTE_BUFFER, b3);
    i_peer.send_bits(8'h3c, 4);
    repeat (6) @(posedge clk);
    rd_reg(sitc_pkg::ADDR_SERIAL_BYTE_BUFFER, 8'ha3);
    repeat (4) @(posedge clk);
    final_report();
  end
endmodule // test_serial_shift_irq_timer_ctrl
